// >>> dslr_top.sv
// Behaviour
// - Test access port with identification and bypass works from boot, regardless of security.
// - Debug read disable blocks all internal memory reads through the debug port.
// - Flash unit drives read disable at reset from stored security bytes.
// - Recovery mass-erases all flash, clearing security and restoring access.
// - Recovery instruction selects a 7-bit erase clock divider data register.
// - During recovery, shifted divider replaces flash timing divider for system clock.
// - Divider bit 6 is prescale-by-eight; bits 5:0 are the clock ratio.
// - After data update, entering Run-Test/Idle starts the lockout erase.
// - Backdoor key unsecures only when backdoor unlock allow is set.
// - Security enabled at boot means secure mode, debug port disabled.
`timescale 1ns/1ps
module dslr_top
   import dslr_pkg::*;
(
   // System
   input  wire logic       CLOCK_IN,
   input  wire logic       RST_IN,
   // Test port pins
   input  wire logic       TCK_IN,
   input  wire logic       TMS_IN,
   input  wire logic       TDI_IN,
   input  wire logic       TRST_N_IN,
   output logic            TDO_OUT,
   output logic            TDO_OE_OUT,
   // Flash unit
   input  wire logic       SECURITY_ENABLED_IN,
   input  wire logic       BACKDOOR_UNLOCK_ALLOW_IN,
   input  wire logic       BACKDOOR_KEY_MATCH_IN,
   input  wire logic [6:0] FLASH_TIMING_CLOCK_SETTING_IN,
   input  wire logic       ERASE_DONE_IN,
   output logic [6:0]      FLASH_CLOCK_SETTING_OUT,
   output logic            FLASH_TICK_OUT,
   output logic            MASS_ERASE_START_OUT,
   output logic            RECOVERY_BUSY_OUT,
   // Core debug
   input  wire logic       DEBUG_READ_REQ_IN,
   output logic            DEBUG_READ_GRANT_OUT,
   output logic            DEBUG_READ_DISABLE_OUT,
   output logic            SECURE_MODE_OUT
);

   function automatic dslr_tap_t tap_step(input dslr_tap_t s, input logic tms);
      case (s)
         ST_RESET:    tap_step = tms ? ST_RESET    : ST_IDLE;
         ST_IDLE:     tap_step = tms ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_DR:   tap_step = tms ? ST_SEL_IR   : ST_CAP_DR;
         ST_CAP_DR:   tap_step = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: tap_step = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: tap_step = tms ? ST_UPD_DR   : ST_PAUSE_DR;
         ST_PAUSE_DR: tap_step = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: tap_step = tms ? ST_UPD_DR   : ST_SHIFT_DR;
         ST_UPD_DR:   tap_step = tms ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_IR:   tap_step = tms ? ST_RESET    : ST_CAP_IR;
         ST_CAP_IR:   tap_step = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: tap_step = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: tap_step = tms ? ST_UPD_IR   : ST_PAUSE_IR;
         ST_PAUSE_IR: tap_step = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: tap_step = tms ? ST_UPD_IR   : ST_SHIFT_IR;
         ST_UPD_IR:   tap_step = tms ? ST_SEL_DR   : ST_IDLE;
         default:     tap_step = ST_RESET;
      endcase
   endfunction

   // Pin synchroniser; test clock is oversampled, so it must run below a quarter of CLOCK_IN
   dslr_pins_t pins_meta;
   dslr_pins_t pins;
   logic       tck_prev;
   logic       tck_rise;
   logic       tck_fall;

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         pins_meta <= '0;
         pins      <= '0;
         tck_prev  <= 1'b0;
      end else begin
         pins_meta <= '{tck: TCK_IN, tms: TMS_IN, tdi: TDI_IN, trst_n: TRST_N_IN};
         pins      <= pins_meta;
         tck_prev  <= pins.tck;
      end
   end

   assign tck_rise = pins.tck & ~tck_prev;
   assign tck_fall = ~pins.tck & tck_prev;

   // Test access controller
   dslr_tap_t       tap, next_tap;
   logic [3:0]      ir, next_ir;
   logic [3:0]      ir_sh, next_ir_sh;
   logic [31:0]     dr_sh, next_dr_sh;
   dslr_div_t       erase_div, next_erase_div;
   logic            div_loaded, next_div_loaded;
   logic            tdo, next_tdo;
   logic            tdo_oe, next_tdo_oe;

   always_comb begin
      next_tap        = tap;
      next_ir         = ir;
      next_ir_sh      = ir_sh;
      next_dr_sh      = dr_sh;
      next_erase_div  = erase_div;
      next_div_loaded = div_loaded;
      next_tdo        = tdo;
      next_tdo_oe     = tdo_oe;
      if (!pins.trst_n) begin
         next_tap        = ST_RESET;
         next_ir         = IR_RESET;
         next_div_loaded = 1'b0;
         next_tdo_oe     = 1'b0;
      end else if (tck_rise) begin
         next_tap = tap_step(tap, pins.tms);
         case (tap)
            ST_RESET: begin
               next_ir         = IR_RESET;
               next_div_loaded = 1'b0;
            end
            ST_CAP_IR:   next_ir_sh = IR_CAPTURE;
            ST_SHIFT_IR: next_ir_sh = {pins.tdi, ir_sh[3:1]};
            ST_UPD_IR:   next_ir    = ir_sh;
            ST_CAP_DR: begin
               case (ir)
                  OP_IDCODE:   next_dr_sh = ID_CODE;
                  OP_RECOVERY: next_dr_sh = {25'h0, erase_div};
                  default:     next_dr_sh = 32'h0;
               endcase
            end
            ST_SHIFT_DR: begin
               case (ir)
                  OP_IDCODE:   next_dr_sh = {pins.tdi, dr_sh[31:1]};
                  OP_RECOVERY: next_dr_sh = {25'h0, pins.tdi, dr_sh[6:1]};
                  default:     next_dr_sh = {31'h0, pins.tdi};
               endcase
            end
            ST_UPD_DR: begin
               if (ir == OP_RECOVERY) begin
                  next_erase_div  = dr_sh[6:0];
                  // erase waits for a loaded divider
                  next_div_loaded = 1'b1;
               end
            end
            default: ;
         endcase
      end else if (tck_fall) begin
         next_tdo_oe = (tap == ST_SHIFT_DR) || (tap == ST_SHIFT_IR);
         next_tdo    = (tap == ST_SHIFT_IR) ? ir_sh[0] : dr_sh[0];
      end
   end

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         tap        <= ST_RESET;
         ir         <= IR_RESET;
         ir_sh      <= IR_CAPTURE;
         dr_sh      <= 32'h0;
         erase_div  <= DIV_RESET;
         div_loaded <= 1'b0;
         tdo        <= 1'b0;
         tdo_oe     <= 1'b0;
      end else begin
         tap        <= next_tap;
         ir         <= next_ir;
         ir_sh      <= next_ir_sh;
         dr_sh      <= next_dr_sh;
         erase_div  <= next_erase_div;
         div_loaded <= next_div_loaded;
         tdo        <= next_tdo;
         tdo_oe     <= next_tdo_oe;
      end
   end

   assign TDO_OUT    = tdo;
   assign TDO_OE_OUT = tdo_oe;

   // Security state and recovery sequencer
   dslr_rec_t rec, next_rec;
   logic      secure, next_secure;
   logic      captured, next_captured;
   logic      erase_start, next_erase_start;

   always_comb begin
      next_rec         = rec;
      next_secure      = secure;
      next_captured    = 1'b1;
      next_erase_start = 1'b0;
      // security taken from flash after reset release
      // secure mode when security bytes set
      if (!captured) begin
         next_secure = SECURITY_ENABLED_IN;
      end else if (BACKDOOR_KEY_MATCH_IN && BACKDOOR_UNLOCK_ALLOW_IN) begin
         next_secure = 1'b0;
      end
      case (rec)
         RC_IDLE: begin
            // erase begins in Run-Test/Idle after update
            if (captured && tap == ST_IDLE && ir == OP_RECOVERY && div_loaded) begin
               next_rec         = RC_ERASE;
               next_erase_start = 1'b1;
            end
         end
         RC_ERASE: begin
            if (ERASE_DONE_IN) begin
               next_rec    = RC_DONE;
               next_secure = 1'b0;
            end
         end
         // Stays here until a test reset, so one load gives one erase
         RC_DONE: begin
            if (tap == ST_RESET) begin
               next_rec = RC_IDLE;
            end
         end
         default: next_rec = RC_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rec         <= RC_IDLE;
         secure      <= 1'b1;
         captured    <= 1'b0;
         erase_start <= 1'b0;
      end else begin
         rec         <= next_rec;
         secure      <= next_secure;
         captured    <= next_captured;
         erase_start <= next_erase_start;
      end
   end

   assign DEBUG_READ_GRANT_OUT   = DEBUG_READ_REQ_IN & ~secure & captured;
   assign DEBUG_READ_DISABLE_OUT = secure;
   assign SECURE_MODE_OUT        = secure;
   assign MASS_ERASE_START_OUT   = erase_start;
   assign RECOVERY_BUSY_OUT      = (rec == RC_ERASE);

   // Flash timing tick divider
   dslr_div_t                 act_div;
   logic [TICK_CNT_WIDTH-1:0] tick_cnt, next_tick_cnt;
   logic [TICK_CNT_WIDTH-1:0] tick_last;
   logic                      tick, next_tick;

   assign act_div = (rec == RC_ERASE) ? erase_div : dslr_div_t'(FLASH_TIMING_CLOCK_SETTING_IN);

   // bit 6 prescale, bits 5:0 ratio
   assign tick_last = TICK_CNT_WIDTH'(FLASH_IN_DIV * (act_div.prescale_by_eight ? PRESCALE_FACTOR : 1)
                                      * (int'(act_div.ratio) + 1) - 1);

   always_comb begin
      next_tick     = 1'b0;
      next_tick_cnt = tick_cnt + 1'b1;
      if (tick_cnt >= tick_last) begin
         next_tick_cnt = '0;
         next_tick     = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         tick_cnt <= '0;
         tick     <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick     <= next_tick;
      end
   end

   assign FLASH_CLOCK_SETTING_OUT = act_div;
   assign FLASH_TICK_OUT          = tick;

endmodule

// >>> dslr_pkg.sv
package dslr_pkg;

   // Test instruction register
   localparam int          IR_WIDTH         = 4;
   localparam logic [3:0]  OP_IDCODE        = 4'h2;
   localparam logic [3:0]  OP_RECOVERY      = 4'h8;
   localparam logic [3:0]  OP_BYPASS        = 4'hF;
   localparam logic [3:0]  IR_CAPTURE       = 4'h1;
   localparam logic [3:0]  IR_RESET         = OP_IDCODE;

   // Identification value is arbitrary
   localparam logic [31:0] ID_CODE          = 32'h1234_5001;

   // Erase clock divider layout
   localparam int          DIV_WIDTH        = 7;
   localparam int          DIV_PRESCALE_BIT = 6;
   localparam int          DIV_RATIO_MSB    = 5;
   localparam logic [6:0]  DIV_RESET        = 7'h00;

   // Flash input clock is the system clock halved; prescale divides by eight more
   localparam int          FLASH_IN_DIV     = 2;
   localparam int          PRESCALE_FACTOR  = 8;
   localparam int          TICK_CNT_WIDTH   = 11;

   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
      ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
      ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } dslr_tap_t;

   typedef enum logic [1:0] {
      RC_IDLE, RC_ERASE, RC_DONE
   } dslr_rec_t;

   typedef struct packed {
      logic       prescale_by_eight;
      logic [5:0] ratio;
   } dslr_div_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } dslr_pins_t;

endpackage

// >>> dslr_chk.sv
`timescale 1ns/1ps
module dslr_chk (
   // Watched top ports
   input wire logic       CLOCK_IN,
   input wire logic       RST_IN,
   input wire logic       SECURITY_ENABLED_IN,
   input wire logic       BACKDOOR_UNLOCK_ALLOW_IN,
   input wire logic [6:0] FLASH_TIMING_CLOCK_SETTING_IN,
   input wire logic       ERASE_DONE_IN,
   input wire logic [6:0] FLASH_CLOCK_SETTING_OUT,
   input wire logic       FLASH_TICK_OUT,
   input wire logic       MASS_ERASE_START_OUT,
   input wire logic       RECOVERY_BUSY_OUT,
   input wire logic       DEBUG_READ_REQ_IN,
   input wire logic       DEBUG_READ_GRANT_OUT,
   input wire logic       DEBUG_READ_DISABLE_OUT,
   input wire logic       SECURE_MODE_OUT
);
   logic live;
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (RST_IN);
   // Boot security is only valid once the first edge after reset has passed
   always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
      if (RST_IN) live <= 1'b0;
      else live <= 1'b1;
   end
   a_grant_rule: assert property (live |-> DEBUG_READ_GRANT_OUT == (DEBUG_READ_REQ_IN && !SECURE_MODE_OUT))
      else $error("grant wrong");
   a_disable_boot: assert property ($rose(live) |-> DEBUG_READ_DISABLE_OUT == $past(SECURITY_ENABLED_IN))
      else $error("read disable not from security bytes");
   a_boot_capture: assert property ($rose(live) |-> SECURE_MODE_OUT == $past(SECURITY_ENABLED_IN))
      else $error("boot security lost");
   a_start_pulse: assert property (MASS_ERASE_START_OUT |-> RECOVERY_BUSY_OUT ##1 !MASS_ERASE_START_OUT)
      else $error("start pulse wrong");
   a_busy_holds: assert property (RECOVERY_BUSY_OUT && !ERASE_DONE_IN |=> RECOVERY_BUSY_OUT)
      else $error("erase dropped");
   a_done_clears: assert property (RECOVERY_BUSY_OUT && ERASE_DONE_IN |=>
      !RECOVERY_BUSY_OUT && !SECURE_MODE_OUT) else $error("erase end kept lock");
   a_setting_mux: assert property (!RECOVERY_BUSY_OUT |->
      FLASH_CLOCK_SETTING_OUT == FLASH_TIMING_CLOCK_SETTING_IN) else $error("setting not passed");
   a_setting_still: assert property (RECOVERY_BUSY_OUT && $past(RECOVERY_BUSY_OUT) |->
      $stable(FLASH_CLOCK_SETTING_OUT)) else $error("divider moved");
   a_tick_single: assert property (FLASH_TICK_OUT |=> !FLASH_TICK_OUT)
      else $error("tick too long");
   a_backdoor_gate: assert property (live && !BACKDOOR_UNLOCK_ALLOW_IN &&
      !RECOVERY_BUSY_OUT && SECURE_MODE_OUT |=> SECURE_MODE_OUT) else $error("secure dropped");
   c_erase: cover property (MASS_ERASE_START_OUT);
   c_unlock: cover property (SECURE_MODE_OUT ##1 !SECURE_MODE_OUT);
   c_tick: cover property (FLASH_TICK_OUT && RECOVERY_BUSY_OUT);
endmodule
bind dslr_top dslr_chk chk (.*);

// >>> dslr_host.sv
`timescale 1ns/1ps
module dslr_host
   import dslr_pkg::*;
(
   // System side
   input  wire logic clk,
   input  wire logic tdo,
   // Test port pins
   output dslr_pins_t pins
);
   initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b0};
   // Phases of 8 system clocks keep the two-flop sampler ahead
   task automatic step(input logic ms, input logic di, output logic seen);
      @(posedge clk);
      #1 pins.tms = ms;
      pins.tdi = di;
      repeat (8) @(posedge clk);
      #1 pins.tck = 1'b1;
      seen = tdo;
      repeat (8) @(posedge clk);
      #1 pins.tck = 1'b0;
   endtask
   task automatic idle(input int n);
      logic s;
      repeat (n) step(1'b0, 1'($urandom), s);
   endtask
   task automatic tap_reset(input logic hard);
      logic s;
      @(posedge clk);
      #1 pins.trst_n = ~hard;
      repeat (8) @(posedge clk);
      #1 pins.trst_n = 1'b1;
      repeat (5) step(1'b1, 1'b0, s);
      step(1'b0, 1'b1, s);
   endtask
   task automatic shift(input logic ir, input logic [31:0] v, input int n, output logic [31:0] got);
      logic s;
      got = '0;
      step(1'b1, 1'b0, s);
      if (ir) step(1'b1, 1'b1, s);
      step(1'b0, 1'b0, s);
      step(1'b0, 1'b1, s);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, v[i], s);
         got[i] = s;
      end
      step(1'b1, ~v[n-1], s);
      step(1'b0, v[n-1], s);
   endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import dslr_pkg::*;
   logic        clk, rst, sec_en, allow, key, done, req, tdo, tdo_oe, tick, start, busy, grant, dis, sec;
   logic [6:0]  fset, set_o, d;
   logic [31:0] got;
   logic [6:0]  exp_q[$];
   dslr_pins_t  pins;
   int          err_total, checks_done, g;
   logic        oe_hi;
   dslr_host host (.clk(clk), .tdo(tdo), .pins(pins));
   dslr_top dut (.CLOCK_IN(clk), .RST_IN(rst), .TCK_IN(pins.tck), .TMS_IN(pins.tms), .TDI_IN(pins.tdi),
      .TRST_N_IN(pins.trst_n), .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe), .SECURITY_ENABLED_IN(sec_en),
      .BACKDOOR_UNLOCK_ALLOW_IN(allow), .BACKDOOR_KEY_MATCH_IN(key), .FLASH_TIMING_CLOCK_SETTING_IN(fset),
      .ERASE_DONE_IN(done), .FLASH_CLOCK_SETTING_OUT(set_o), .FLASH_TICK_OUT(tick),
      .MASS_ERASE_START_OUT(start), .RECOVERY_BUSY_OUT(busy), .DEBUG_READ_REQ_IN(req),
      .DEBUG_READ_GRANT_OUT(grant), .DEBUG_READ_DISABLE_OUT(dis), .SECURE_MODE_OUT(sec));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s: expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic at();
      @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic on_done);
      at();
      if (on_done) done = 1'b1;
      else key = 1'b1;
      at();
      done = 1'b0;
      key = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic boot(input logic s);
      at();
      rst = 1'b1;
      sec_en = s;
      req = s;
      fset = 7'($urandom);
      repeat (3) at();
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk("secure", s, sec);
      chk("grant", 0, grant);
      chk("setting", fset, set_o);
   endtask
   // First gap after a divider change may be short, so callers measure twice
   task automatic tick_gap();
      int c;
      c = 0;
      g = 0;
      while (tick !== 1'b1 && c < 1100) begin
         @(negedge clk);
         c++;
      end
      do begin
         @(negedge clk);
         g++;
      end while (tick !== 1'b1 && g < 1100);
   endtask
   // Remembers that the output enable was seen high during a shift
   always @(negedge clk) begin
      if (rst === 1'b1) oe_hi <= 1'b0;
      else if (tdo_oe === 1'b1) oe_hi <= 1'b1;
   end
   always @(negedge clk) begin
      if (start === 1'b1 && exp_q.size() == 0) chk("unplanned start", 0, 1);
      else if (start === 1'b1) chk("erase divider", exp_q.pop_front(), set_o);
   end
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #2_000_000;
      err_total++;
      stop_test();
   end
   initial begin
      void'($urandom(10));
      {rst, sec_en, allow, key, done, req} = 6'b110001;
      fset = 7'($urandom);
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(negedge clk);
      chk("secure", 1, sec);
      chk("read disable", 1, dis);
      chk("grant", 0, grant);
      host.tap_reset(1'b1);
      host.shift(1'b0, 32'($urandom), 32, got);
      chk("id", ID_CODE, got);
      chk("tdo enable seen", 1, oe_hi);
      chk("tdo enable", 0, tdo_oe);
      host.shift(1'b1, 32'(OP_BYPASS), 4, got);
      chk("ir capture", 32'(IR_CAPTURE), got);
      host.shift(1'b0, 32'h1, 2, got);
      chk("bypass", 32'h2, got);
      pulse(1'b0);
      chk("secure", 1, sec);
      for (int k = 0; k < 2; k++) begin
         host.tap_reset(k == 0);
         host.shift(1'b1, 32'(OP_RECOVERY), 4, got);
         host.idle(3);
         d = k ? 7'(64 + $urandom % 64) : 7'(49 + $urandom % 15);
         exp_q.push_back(d);
         host.shift(1'b0, 32'(d), 7, got);
         chk("busy", 1, busy);
         tick_gap();
         tick_gap();
         chk("tick gap", 2 * (d[6] ? 8 : 1) * (d[5:0] + 1), g);
         host.idle(2);
         pulse(1'b1);
         chk("busy", 0, busy);
         chk("secure", 0, sec);
         chk("grant", 1, grant);
         host.idle(3);
      end
      host.tap_reset(1'b1);
      boot(1'b0);
      boot(1'b1);
      at();
      allow = 1'b1;
      pulse(1'b0);
      chk("secure", 0, sec);
      chk("grant", 1, grant);
      stop_test();
   end
endmodule
